/* File: design/sdram_mode_setup.v */
/*
  mode-set decoder and burst planner inside the memory device: termination
  gating after reset, operating mode register capture and burst order.
  assumes command pins already in the device's clock domain; clock enable
  and reset pins come from outside and are synchronised here.
*/
// Behaviour
// - termination off during reset and until clock enable is seen high.
// - all bank bits low decodes as write to register zero.
// - register zero selects burst length mode and burst order.
// - burst order from start column: rotate in group or xor.
// - chopped read tri-states last four beats; chopped write uses bit two.
// - fixed chop starts internal write two clocks earlier.
// - read latency is column latency plus added latency.
// - lock reset bit self-clears after taking effect.
// - power-down exit mode freezes or keeps lock loop running.
`timescale 1ns/1ns
`include "sdram_mode_regs.vh"

module sdram_mode_setup #(
  parameter ADDED_LATENCY = 0
) (
  // clock and reset
  input  wire                    mclk,
  input  wire                    reset,
  // asynchronous pins
  input  wire                    device_reset_n,
  input  wire                    clock_enable_pin,
  input  wire                    termination_enable_pin,
  // command pins
  input  wire                    cs_n,
  input  wire                    ras_n,
  input  wire                    cas_n,
  input  wire                    we_n,
  input  wire [2:0]              bank_addr,
  input  wire [12:0]             addr,
  // termination, lock and mode register status
  output reg                     termination_on,
  output reg                     lock_reset_pulse,
  output reg                     pd_fast_exit,
  output reg  [12:0]             operating_mode,
  // burst plan of last read or write
  output reg                     burst_start,
  output reg                     burst_is_write,
  output reg                     burst_chop,
  output reg  [23:0]             burst_order,
  output reg  [7:0]              beat_drive,
  output reg  [3:0]              write_start_shift,
  output reg  [4:0]              read_latency
);

  // ==========================================================
  // pin synchronisers
  reg  [1:0] rst_sync_reg;
  reg  [1:0] cke_sync_reg;
  reg  [1:0] odt_sync_reg;
  reg        cke_seen_reg;
  reg [12:0] opm_reg;
  wire       pins_reset = reset | ~rst_sync_reg[1];

  // device reset pin
  always @(posedge mclk) begin
    if (reset) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], device_reset_n};
    end
  end

  // clock enable pin
  always @(posedge mclk) begin
    if (reset) begin
      cke_sync_reg <= 2'h0;
    end else begin
      cke_sync_reg <= {cke_sync_reg[0], clock_enable_pin};
    end
  end

  // termination enable pin
  always @(posedge mclk) begin
    if (reset) begin
      odt_sync_reg <= 2'h0;
    end else begin
      odt_sync_reg <= {odt_sync_reg[0], termination_enable_pin};
    end
  end

  // ==========================================================
  // burst order helper
  function [2:0] beat_index;
    input [2:0] start;
    input [2:0] beat;
    input       interleave;
    begin
      if (interleave)
        beat_index = start ^ beat;
      else
        beat_index = {start[2] ^ beat[2], start[1:0] + beat[1:0]};
    end
  endfunction

  // ==========================================================
  // command match helper
  function is_cmd;
    input [2:0] pins;
    input [2:0] code;
    begin
      is_cmd = (pins == code);
    end
  endfunction

  // ==========================================================
  // command decode
  localparam [31:0] ADDED_LAT_W = ADDED_LATENCY;
  wire       selected = ~cs_n & cke_sync_reg[1];
  wire [2:0] cmd      = {ras_n, cas_n, we_n};
  wire       mode_set = selected && is_cmd(cmd, `CMD_MODE_SET) && (bank_addr == 3'h0);
  wire       rd_cmd   = selected && is_cmd(cmd, `CMD_READ);
  wire       wr_cmd   = selected && is_cmd(cmd, `CMD_WRITE);
  wire [1:0] bl_code  = opm_reg[`OPM_BL_HI:`OPM_BL_LO];
  wire       chop_now = (bl_code == `BL_FIXED_CHOP) ||
                        ((bl_code == `BL_ON_THE_FLY) && ~addr[`CHOP_SELECT_BIT]);
  wire [3:0] cl_code  = {opm_reg[`OPM_CL_HI_HI:`OPM_CL_HI_LO], opm_reg[`OPM_CL_LOW_BIT]};
  wire [4:0] lat_next = {1'b0, cl_code} + `CL_BASE + ADDED_LAT_W[4:0];
  wire [2:0] start_col = (wr_cmd && chop_now) ? {addr[2], 2'h0} : addr[2:0];

  integer i;
  reg [23:0] order_next;
  always @* begin
    order_next = 24'h000000;
    for (i = 0; i < 8; i = i + 1)
      order_next[i*3 +: 3] = beat_index(start_col, i[2:0], opm_reg[`OPM_ORDER_BIT]);
  end

  // ==========================================================
  // termination gating
  always @(posedge mclk) begin
    if (pins_reset) begin
      cke_seen_reg   <= 1'b0;
      termination_on <= 1'b0;
    end else begin
      if (cke_sync_reg[1]) begin
        cke_seen_reg <= 1'b1;
      end
      termination_on <= cke_seen_reg & odt_sync_reg[1];
    end
  end

  // ==========================================================
  // operating mode register
  always @(posedge mclk) begin
    if (pins_reset) begin
      opm_reg          <= `OPM_RESET;
      operating_mode   <= `OPM_RESET;
      lock_reset_pulse <= 1'b0;
      pd_fast_exit     <= 1'b0;
    end else begin
      lock_reset_pulse <= 1'b0;
      if (mode_set) begin
        opm_reg                    <= addr;
        opm_reg[`OPM_LOCK_RST_BIT] <= 1'b0;
        operating_mode             <= addr;
        operating_mode[`OPM_LOCK_RST_BIT] <= 1'b0;
        lock_reset_pulse           <= addr[`OPM_LOCK_RST_BIT];
        pd_fast_exit               <= addr[`OPM_PD_FAST_BIT];
      end
    end
  end

  // ==========================================================
  // burst plan
  always @(posedge mclk) begin
    if (pins_reset) begin
      burst_start       <= 1'b0;
      burst_is_write    <= 1'b0;
      burst_chop        <= 1'b0;
      burst_order       <= 24'h000000;
      beat_drive        <= 8'h00;
      write_start_shift <= 4'h0;
      read_latency      <= 5'h00;
    end else begin
      burst_start <= 1'b0;
      if (rd_cmd | wr_cmd) begin
        burst_start    <= 1'b1;
        burst_is_write <= wr_cmd;
        burst_chop     <= chop_now;
        burst_order    <= order_next;
        beat_drive     <= (rd_cmd && chop_now) ? 8'h0F : 8'hFF;
        write_start_shift <= (wr_cmd && bl_code == `BL_FIXED_CHOP) ?
                             `CHOP_PULL_IN : 4'h0;
        read_latency   <= lat_next;
      end
    end
  end

endmodule // sdram_mode_setup

/* File: design/sdram_mode_regs.vh */
/*
  shared constants of the mode-set decoder: command codes, field positions,
  burst length codes and timing figures.
  assumes inclusion by bare name from the design file.
*/
`ifndef SDRAM_MODE_REGS_VH
`define SDRAM_MODE_REGS_VH

// ==========================================================
// command encoding {ras_n, cas_n, we_n}
`define CMD_MODE_SET      3'h0
`define CMD_READ          3'h5
`define CMD_WRITE         3'h4
`define CMD_IDLE          3'h7
`define CMD_CALIBRATE     3'h6

// ==========================================================
// operating mode register fields
`define OPM_WIDTH         13
`define OPM_RESET         13'h0000
`define OPM_BL_LO         0
`define OPM_BL_HI         1
`define OPM_CL_LOW_BIT    2
`define OPM_ORDER_BIT     3
`define OPM_CL_HI_LO      4
`define OPM_CL_HI_HI      6
`define OPM_TEST_BIT      7
`define OPM_LOCK_RST_BIT  8
`define OPM_WR_LO         9
`define OPM_WR_HI         11
`define OPM_PD_FAST_BIT   12
`define CHOP_SELECT_BIT   12

// ==========================================================
// burst length codes
`define BL_FIXED_EIGHT    2'h0
`define BL_ON_THE_FLY     2'h1
`define BL_FIXED_CHOP     2'h2

// ==========================================================
// timing figures
`define LOCK_RST_PULSE    4'h1
`define CHOP_PULL_IN      4'h2
`define CL_BASE           5'h04

`endif

/* File: bench/mode_setup_assertions.sv */
/* port checker of the mode-set decoder.
   assumes a bind to sdram_mode_setup. */
`timescale 1ns/1ns
`include "sdram_mode_regs.vh"
// ==================================================
// checker
module mode_setup_assertions #(parameter ADDED_LATENCY = 0) (
  // clock, reset, pins
  input wire        mclk,
  input wire        reset,
  input wire        device_reset_n,
  input wire        clock_enable_pin,
  input wire        cs_n,
  input wire        ras_n,
  input wire        cas_n,
  input wire        we_n,
  input wire [2:0]  bank_addr,
  input wire [12:0] addr,
  // outputs
  input wire        termination_on,
  input wire        lock_reset_pulse,
  input wire [12:0] operating_mode,
  input wire        burst_start,
  input wire        burst_is_write,
  input wire        burst_chop,
  input wire [7:0]  beat_drive,
  input wire [3:0]  write_start_shift,
  input wire [4:0]  read_latency
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  sequence s_live; (clock_enable_pin && device_reset_n)[*3]; endsequence
  sequence s_mset; !cs_n && !ras_n && !cas_n && !we_n; endsequence
  property p_term; !device_reset_n[*4] |=> !termination_on; endproperty
  a_term: assert property (p_term) else $error("termination on in reset");
  property p_lock; s_live ##0 s_mset ##0 (bank_addr == 3'h0 && addr[8]) |=> lock_reset_pulse; endproperty
  a_lock: assert property (p_lock) else $error("no lock reset pulse");
  property p_clr; lock_reset_pulse |=> !lock_reset_pulse; endproperty
  a_clr: assert property (p_clr) else $error("lock reset not cleared");
  property p_opm; s_live ##0 s_mset ##0 bank_addr == 3'h0 |=> operating_mode == ($past(addr) & 13'h1EFF); endproperty
  a_opm: assert property (p_opm) else $error("mode register value wrong");
  property p_bank; s_live ##0 s_mset ##0 bank_addr != 3'h0 |=> $stable(operating_mode); endproperty
  a_bank: assert property (p_bank) else $error("other bank changed mode");
  property p_drive; burst_start && !burst_is_write |-> beat_drive == (burst_chop ? 8'h0F : 8'hFF); endproperty
  a_drive: assert property (p_drive) else $error("beat drive wrong");
  property p_shift; burst_start |-> write_start_shift ==
    {2'h0, burst_is_write && operating_mode[1:0] == `BL_FIXED_CHOP, 1'b0}; endproperty
  a_shift: assert property (p_shift) else $error("write shift wrong");
  property p_lat; burst_start && operating_mode[6:4] == 3'h0 && !operating_mode[2] |->
    read_latency == 5'h4 + ADDED_LATENCY; endproperty
  a_lat: assert property (p_lat) else $error("read latency wrong");
endmodule // mode_setup_assertions
bind sdram_mode_setup mode_setup_assertions #(.ADDED_LATENCY(ADDED_LATENCY)) chk (.*);

/* File: bench/ctrl_model.sv */
/* controller model driving pins and commands.
   assumes commands sampled on rising mclk. */
`timescale 1ns/1ns
`include "sdram_mode_regs.vh"
// ==================================================
// model
module ctrl_model (
  // clock
  input  wire        mclk,
  // pins
  output reg         device_reset_n,
  output reg         clock_enable_pin,
  output reg         termination_enable_pin,
  // command
  output reg         cs_n,
  output reg         ras_n,
  output reg         cas_n,
  output reg         we_n,
  output reg  [2:0]  bank_addr,
  output reg  [12:0] addr
);
  initial begin
    {device_reset_n, clock_enable_pin, termination_enable_pin, cs_n} = 4'h3;
    {ras_n, cas_n, we_n, bank_addr, addr} = {`CMD_IDLE, 16'h0000};
  end
  task pins(input r, input k, input o);
    begin
      @(negedge mclk);
      {device_reset_n, clock_enable_pin, termination_enable_pin} = {r, k, o};
    end
  endtask
  task issue(input [2:0] c, input [2:0] b, input [12:0] a);
    begin
      @(negedge mclk);
      {cs_n, ras_n, cas_n, we_n} = {1'b0, c};
      bank_addr = {1'b0, b[1:0]};
      addr = a & 13'h1F7F;
      @(negedge mclk);
      {cs_n, ras_n, cas_n, we_n, bank_addr, addr} = {1'b1, `CMD_IDLE, ~bank_addr, ~addr};
      repeat (4) @(negedge mclk);
    end
  endtask
endmodule // ctrl_model

/* File: bench/testbench.sv */
/* self-checking bench of the mode-set decoder.
   assumes the controller model and the bound checker. */
`timescale 1ns/1ns
`include "sdram_mode_regs.vh"
// ==================================================
// bench
module testbench;
  reg         mclk, reset;
  wire        device_reset_n, clock_enable_pin, termination_enable_pin, cs_n, ras_n, cas_n, we_n;
  wire        termination_on, lock_reset_pulse, pd_fast_exit, burst_start, burst_is_write, burst_chop;
  wire [2:0]  bank_addr;
  wire [12:0] addr, operating_mode;
  wire [23:0] burst_order;
  wire [7:0]  beat_drive;
  wire [3:0]  write_start_shift;
  wire [4:0]  read_latency;
  integer     fails = 0, tests_run = 0, s, o, i;
  reg  [23:0] exp;
  sdram_mode_setup #(.ADDED_LATENCY(2)) DUT (.*);
  ctrl_model ctl (.*);
  task check(input [23:0] got, input [23:0] want);
    begin
      tests_run = tests_run + 1;
      if (got !== want) begin
        fails = fails + 1;
        $display("ERROR t=%0t got %h want %h", $time, got, want);
      end
    end
  endtask
  task close_out;
    begin
      $display("checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
    end
  endtask
  initial begin
    mclk = 0;
    forever #20 mclk = ~mclk;
  end
  initial begin
    repeat (20000) @(posedge mclk);
    fails = fails + 1;
    close_out;
  end
  initial begin
    reset = 1;
    repeat (4) @(negedge mclk);
    reset = 0;
    ctl.pins(1'b1, 1'b0, 1'b1);
    repeat (6) @(negedge mclk);
    check(termination_on, 0);
    ctl.pins(1'b1, 1'b1, 1'b1);
    repeat (6) @(negedge mclk);
    check(termination_on, 1);
    ctl.issue(`CMD_MODE_SET, 3'h2, 13'h0000);
    ctl.issue(`CMD_MODE_SET, 3'h3, 13'h0000);
    ctl.issue(`CMD_MODE_SET, 3'h1, 13'h0000);
    ctl.issue(`CMD_MODE_SET, 3'h0, 13'h0300);
    check(operating_mode, 13'h0200);
    ctl.issue(`CMD_CALIBRATE, 3'h0, 13'h0400);
    check(operating_mode, 13'h0200);
    $display("test init done");
    for (o = 0; o < 2; o = o + 1) begin
      ctl.issue(`CMD_MODE_SET, 3'h0, {1'b1, 8'h00, o[0], 3'h0});
      check(pd_fast_exit, 1);
      for (s = 0; s < 8; s = s + 1) begin
        ctl.issue(`CMD_READ, 3'h0, s[12:0]);
        for (i = 0; i < 8; i = i + 1) exp[3*i+:3] = o[0] ? s[2:0] ^ i[2:0] : {s[2] ^ i[2], s[1:0] + i[1:0]};
        check(burst_order, exp);
        check({beat_drive, read_latency}, {8'hFF, 5'h6});
      end
    end
    $display("test order done");
    ctl.issue(`CMD_MODE_SET, 3'h0, 13'h0002);
    ctl.issue(`CMD_READ, 3'h0, 13'h0005);
    check(beat_drive, 8'h0F);
    ctl.issue(`CMD_WRITE, 3'h0, 13'h0007);
    check({pd_fast_exit, write_start_shift, burst_order[11:0]}, 17'h02FAC);
    ctl.issue(`CMD_MODE_SET, 3'h0, 13'h0001);
    ctl.issue(`CMD_WRITE, 3'h0, 13'h1003);
    check({burst_chop, write_start_shift}, 0);
    ctl.issue(`CMD_READ, 3'h0, 13'h0003);
    check({burst_chop, beat_drive}, 9'h10F);
    ctl.pins(1'b1, 1'b0, 1'b1);
    ctl.pins(1'b0, 1'b0, 1'b1);
    repeat (6) @(negedge mclk);
    check({termination_on, operating_mode}, 0);
    $display("test chop and reset done");
    close_out;
  end
endmodule // testbench
